// >>> hdl/fan_tach_pkg.sv
// Shared constants, types and decoding for the two-channel fan tachometer block.
// Assumes a single 100 MHz clock and a classic Wishbone slave with 32-bit data.
package fan_tach_pkg;

  // Clock figures.
  localparam int CLK_PERIOD_NS = 10;

  // Base period of one tachometer count tick before the divisor is applied.
  localparam int TACH_BASE_NS = 10000;
  localparam int TACH_BASE_CYCLES_INT = (TACH_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [12:0] TACH_BASE_CYCLES = 13'(TACH_BASE_CYCLES_INT);

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] FIRST_COUNT_OFFSET = 8'h04;
  localparam logic [7:0] SECOND_COUNT_OFFSET = 8'h08;

  // Control register field positions.
  localparam int FIRST_SPEED_SEL_BIT = 0;
  localparam int SECOND_SPEED_SEL_BIT = 1;
  localparam int FIRST_MULT_BIT = 2;
  localparam int SECOND_MULT_BIT = 3;
  localparam int FIRST_DIV_LSB = 4;
  localparam int SECOND_DIV_LSB = 6;

  // Reset values: both divisors select 2, no multiplier, counts cleared.
  localparam logic [7:0] CTRL_RESET = 8'h50;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;

  // Divisor codes.
  typedef enum logic [1:0] {
    DIV_BY_1 = 2'b00,
    DIV_BY_2 = 2'b01,
    DIV_BY_4 = 2'b10,
    DIV_BY_8 = 2'b11
  } div_code_t;

  // Settings that one channel samples at the start of each fan pulse.
  typedef struct packed {
    div_code_t div_code;
    logic mult;
  } chan_cfg_t;

  // Clock cycles per count tick for a divisor code.
  function automatic logic [12:0] tick_cycles(input div_code_t code);
    logic [12:0] cyc;
    cyc = TACH_BASE_CYCLES;
    case (code)
      DIV_BY_1: tick_cycles = cyc;
      DIV_BY_2: tick_cycles = 13'(cyc << 1);
      DIV_BY_4: tick_cycles = 13'(cyc << 2);
      DIV_BY_8: tick_cycles = 13'(cyc << 3);
      default: tick_cycles = cyc;
    endcase
  endfunction

endpackage

// >>> hdl/fan_pulse_counter.sv
// One tachometer channel: counts ticks across one fan pulse and latches the result.
// Assumes i_tach is already synchronised to i_clk and i_rst_n is a released reset copy.
`timescale 1ns/1ps
module fan_pulse_counter (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tach,
  input wire fan_tach_pkg::chan_cfg_t i_cfg,
  output logic [7:0] o_count
);

  logic tach_prev_q;
  logic pulse_edge;
  fan_tach_pkg::chan_cfg_t cfg_q;
  logic [12:0] presc_q;
  logic [7:0] run_q;
  logic [7:0] latch_q;
  logic tick;
  logic [8:0] run_step;

  // A fan pulse runs from one rising tachometer edge to the next.
  assign pulse_edge = i_tach & ~tach_prev_q;
  assign tick = (presc_q == 13'(fan_tach_pkg::tick_cycles(cfg_q.div_code) - 13'h0001));
  // With the multiplier set each tick counts double, so the count saturates sooner.
  assign run_step = {1'b0, run_q} + (cfg_q.mult ? 9'h002 : 9'h001);

  // Edge detector on the synchronised input.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tach_prev_q <= 1'b0;
    end else begin
      tach_prev_q <= i_tach;
    end
  end

  // Settings are taken only at a pulse boundary so a running measurement stays coherent.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_q <= fan_tach_pkg::chan_cfg_t'({fan_tach_pkg::DIV_BY_2, 1'b0});
    end else if (pulse_edge) begin
      cfg_q <= i_cfg;
    end
  end

  // Prescaler divides the clock into count ticks.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      presc_q <= 13'h0000;
    end else if (pulse_edge || tick) begin
      presc_q <= 13'h0000;
    end else begin
      presc_q <= presc_q + 13'h0001;
    end
  end

  // Running count saturates rather than wrapping, so a pulse too slow to count reads full scale; a stalled fan keeps its last count.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_q <= fan_tach_pkg::COUNT_RESET;
    end else if (pulse_edge) begin
      run_q <= fan_tach_pkg::COUNT_RESET;
    end else if (tick) begin
      run_q <= run_step[8] ? fan_tach_pkg::COUNT_MAX : run_step[7:0];
    end
  end

  // The final count of the pulse just ended is what software sees.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      latch_q <= fan_tach_pkg::COUNT_RESET;
    end else if (pulse_edge) begin
      latch_q <= run_q;
    end
  end

  assign o_count = latch_q;

endmodule

// >>> hdl/fan_tachometer_counter.sv
// Two-channel fan tachometer with a classic Wishbone register slave.
// Assumes one 100 MHz clock, asynchronous fan tachometer pins and a standby power-on reset.
`timescale 1ns/1ps
module fan_tachometer_counter (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_first_fan_channel,
  input wire logic i_second_fan_channel,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack
);

  // Register map. Each 8-bit register sits in the low byte of its own 32-bit word.
  // Offset 0x00 is the control register, which software may read and write.
  // Control bits 1:0 are speed selects that are only stored and read back here.
  // Control bit 2 doubles the first channel's count and bit 3 the second channel's.
  // Control bits 5:4 and 7:6 are the first and second channel's count divisors.
  // Offsets 0x04 and 0x08 hold the two latched pulse counts and are read only.
  // Any other offset is acknowledged, reads as zero and drops writes.
  // A new setting only reaches a channel at its next pulse, so software should
  // wait two pulses after a change before it trusts a count again.
  // A request is taken at the first edge that sees cyc and stb while no answer is
  // pending; ack follows one cycle later for exactly one cycle, and read data stand
  // until the next request is taken.

  // Reset release synchroniser.
  logic rst_meta_q;
  logic rst_n_q;

  // Tachometer pin synchronisers, one pair of flops per channel.
  logic [1:0] tach_pin;
  logic [1:0] tach_meta_q;
  logic [1:0] tach_sync_q;

  // Control register and per-channel results.
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  fan_tach_pkg::chan_cfg_t chan_cfg [2];
  logic [7:0] chan_count [2];

  // Bus decode.
  logic req;
  logic wr_ctrl;
  logic [7:0] rd_byte;
  logic ack_q;
  logic [31:0] dat_q;

  // Bus states: idle, or answering during the single ack cycle.
  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } bus_state_t;
  bus_state_t bus_q;
  bus_state_t bus_d;

  // Register selected by a bus offset. Writes and reads share one decode so the
  // two can never disagree about which offset is which.
  typedef enum logic [1:0] {
    SEL_CTRL,
    SEL_FIRST,
    SEL_SECOND,
    SEL_NONE
  } reg_sel_t;
  reg_sel_t adr_sel;

  function automatic reg_sel_t reg_decode(input logic [7:0] adr);
    case (adr)
      fan_tach_pkg::CTRL_OFFSET: reg_decode = SEL_CTRL;
      fan_tach_pkg::FIRST_COUNT_OFFSET: reg_decode = SEL_FIRST;
      fan_tach_pkg::SECOND_COUNT_OFFSET: reg_decode = SEL_SECOND;
      default: reg_decode = SEL_NONE;
    endcase
  endfunction

  // The reset is asserted at once but released only after two clock edges, so
  // no flop leaves reset on a partial edge.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  assign tach_pin = {i_second_fan_channel, i_first_fan_channel};

  // The fan pins are asynchronous; only the second flop feeds the counters.
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tach_meta_q <= 2'b00;
      tach_sync_q <= 2'b00;
    end else begin
      tach_meta_q <= tach_pin;
      tach_sync_q <= tach_meta_q;
    end
  end

  // Channel settings drawn from the shared control register.
  assign chan_cfg[0] = fan_tach_pkg::chan_cfg_t'({
    ctrl_q[fan_tach_pkg::FIRST_DIV_LSB +: 2],
    ctrl_q[fan_tach_pkg::FIRST_MULT_BIT]});
  assign chan_cfg[1] = fan_tach_pkg::chan_cfg_t'({
    ctrl_q[fan_tach_pkg::SECOND_DIV_LSB +: 2],
    ctrl_q[fan_tach_pkg::SECOND_MULT_BIT]});

  // One measurement channel per fan.
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      fan_pulse_counter u_counter (
        .i_clk(i_clk),
        .i_rst_n(rst_n_q),
        .i_tach(tach_sync_q[ch]),
        .i_cfg(chan_cfg[ch]),
        .o_count(chan_count[ch])
      );
    end
  endgenerate

  // A request is new only while no answer is pending, which keeps one ack per cycle.
  assign req = i_wb_cyc & i_wb_stb & (bus_q == BUS_IDLE);

  // Offset decode, shared by the write strobe and the read multiplexer.
  assign adr_sel = reg_decode(i_wb_adr);

  // Only the control register accepts writes, and only through byte lane 0. The write
  // lands at the edge where the master sees ack, so a cycle dropped before then leaves
  // the register alone.
  assign wr_ctrl = ack_q & i_wb_cyc & i_wb_stb & i_wb_we & i_wb_sel[0] &
    (adr_sel == SEL_CTRL);

  // Next control value; count offsets are absent here, so writes there are dropped.
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = i_wb_dat[7:0];
    end
  end

  // Control register, defaulting to divide by 2 on both channels.
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= fan_tach_pkg::CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Read multiplexer; unmapped offsets read zero but are still acknowledged.
  // Software that probes an unused offset therefore never stalls the bus.
  always_comb begin
    case (adr_sel)
      SEL_CTRL: rd_byte = ctrl_q;
      SEL_FIRST: rd_byte = chan_count[0];
      SEL_SECOND: rd_byte = chan_count[1];
      default: rd_byte = 8'h00;
    endcase
  end

  // Bus state: answer one cycle after the request, then drop ack for a cycle.
  always_comb begin
    case (bus_q)
      BUS_IDLE: bus_d = req ? BUS_ACK : BUS_IDLE;
      BUS_ACK: bus_d = BUS_IDLE;
      default: bus_d = BUS_IDLE;
    endcase
  end

  // Bus state register. Holding the answer state for one cycle keeps a request that
  // is still raised during ack from being taken a second time.
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bus_q <= BUS_IDLE;
    end else begin
      bus_q <= bus_d;
    end
  end

  // Ack is registered so the master sees it one edge after it raised the request.
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // Read data is captured with the request and held until the next request.
  // Narrow registers sit in the low byte; the upper bits always read zero.
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dat_q <= 32'h0000_0000;
    end else if (req) begin
      dat_q <= {24'h00_0000, rd_byte};
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = dat_q;

endmodule

// >>> verification/fan_tach_checker_assertions.sv
// Checker for the fan tachometer register slave, seeing only top-level ports.
// Assumes a master that holds each request until it samples ack.
`timescale 1ns/1ps
module fan_tach_checker (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_first_fan_channel,
  input wire logic i_second_fan_channel,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack
);
  logic [7:0] ctrl_q;
  logic [7:0] seen_q;
  logic [7:0] pin_q;
  logic p1_q;
  logic p2_q;
  logic vld_q;
  logic req;
  logic rd;
  logic near;
  assign req = i_wb_cyc && i_wb_stb;
  assign rd = o_wb_ack && !i_wb_we;
  assign near = (pin_q != 8'h00) && (pin_q != 8'hFF);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Shadow state; a pin edge near a read voids the last count, since the latch may move.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_q <= fan_tach_pkg::CTRL_RESET;
      seen_q <= 8'h00;
      pin_q <= 8'h00;
      p1_q <= 1'b0;
      p2_q <= 1'b0;
      vld_q <= 1'b0;
    end else begin
      pin_q <= {pin_q[6:0], i_first_fan_channel};
      p1_q <= p1_q | i_first_fan_channel;
      p2_q <= p2_q | i_second_fan_channel;
      if (o_wb_ack && req && i_wb_we && i_wb_adr == 8'h00 && i_wb_sel[0]) begin
        ctrl_q <= i_wb_dat[7:0];
      end
      if (near) begin
        vld_q <= 1'b0;
      end else if (rd && i_wb_adr == 8'h04) begin
        seen_q <= o_wb_dat[7:0];
        vld_q <= 1'b1;
      end
    end
  end
  sequence s_taken;
    req && !o_wb_ack;
  endsequence
  a_ack_follows_req: assert property (s_taken |=> o_wb_ack) else $error("ack missing");
  a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  a_ack_has_cause: assert property ($rose(o_wb_ack) |-> $past(req)) else $error("stray ack");
  a_upper_zero: assert property (rd |-> o_wb_dat[31:8] == 24'h000000) else $error("upper bits");
  a_data_holds: assert property (!req |=> $stable(o_wb_dat)) else $error("read data moved");
  a_ctrl_readback: assert property (rd && i_wb_adr == 8'h00 |-> o_wb_dat[7:0] == ctrl_q)
    else $error("ctrl readback");
  a_unmapped_zero: assert property (rd && !(i_wb_adr inside {8'h00, 8'h04, 8'h08})
    |-> o_wb_dat == 32'h00000000) else $error("unmapped read");
  a_count_cleared: assert property (rd && (i_wb_adr == 8'h04 && !p1_q ||
    i_wb_adr == 8'h08 && !p2_q) |-> o_wb_dat == 32'h00000000) else $error("count not clear");
  a_count_latched: assert property (rd && i_wb_adr == 8'h04 && vld_q && !near
    |-> o_wb_dat[7:0] == seen_q) else $error("count moved");
endmodule
bind fan_tachometer_counter fan_tach_checker i_fan_tach_checker (.i_clk, .i_nrst,
  .i_first_fan_channel, .i_second_fan_channel, .i_wb_cyc, .i_wb_stb, .i_wb_we,
  .i_wb_adr, .i_wb_dat, .i_wb_sel, .o_wb_dat, .o_wb_ack);

// >>> verification/fan_pair_model.sv
// Behavioural pair of fan tachometer outputs sharing one period in clock cycles.
// Assumes the bench sets the period; zero keeps both pins low.
`timescale 1ns/1ps
module fan_pair_model (
  input wire logic i_clk,
  input wire logic [15:0] i_period,
  output logic o_first,
  output logic o_second
);
  logic [15:0] cnt_q;
  // Free-running phase; a spinning fan never pauses its pulse train.
  always_ff @(posedge i_clk) begin
    if (i_period == 16'h0000 || cnt_q >= i_period - 16'h0001) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  // The second fan lags a quarter period so the two channels never move together.
  assign o_first = (i_period != 16'h0000) && (cnt_q < (i_period >> 1));
  assign o_second = (i_period != 16'h0000) && (cnt_q >= (i_period >> 2)) &&
    (cnt_q < (i_period >> 2) + (i_period >> 1));
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the two-channel fan tachometer block.
// Assumes the fan pair model drives both pins and the checker is bound.
`timescale 1ns/1ps
module testbench;
  logic clk;
  logic nrst;
  logic cyc;
  logic stb;
  logic we;
  logic ack;
  logic f1;
  logic f2;
  logic [7:0] adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [3:0] sel;
  logic [15:0] period;
  logic [3:0] lanes;
  int fail_count = 0;
  int checks_done = 0;
  fan_tachometer_counter i_fan_tachometer_counter (.i_clk(clk), .i_nrst(nrst),
    .i_first_fan_channel(f1), .i_second_fan_channel(f2), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat),
    .o_wb_ack(ack));
  fan_pair_model i_fan_pair_model (.i_clk(clk), .i_period(period), .o_first(f1),
    .o_second(f2));
  // One classic cycle; the request stands until ack is sampled, then one idle cycle.
  // Only the watchdog ends a wait, so a slave that never answers fails the run.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    sel <= lanes;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Reset values, then writes to read-only and unmapped places, with fans still.
  task automatic t_reset_and_readonly();
    logic [7:0] q;
    bus(1'b0, 8'h00, 8'h00, q);
    chk("ctrl", 8'h50, q);
    bus(1'b1, 8'h04, 8'hFF, q);
    bus(1'b1, 8'h08, 8'hFF, q);
    bus(1'b1, 8'h0C, 8'hFF, q);
    bus(1'b0, 8'h0C, 8'h00, q);
    chk("unmapped", 8'h00, q);
    bus(1'b0, 8'h04, 8'h00, q);
    chk("first count", 8'h00, q);
    bus(1'b0, 8'h08, 8'h00, q);
    chk("second count", 8'h00, q);
  endtask
  // Every divisor code on both channels, multipliers alternating, with 4.5 tick periods.
  task automatic t_divisors();
    logic [7:0] q;
    logic [7:0] c;
    int e1;
    int e2;
    period <= 16'h1194;
    for (int k = 0; k < 4; k++) begin
      c = {2'(3 - k), 2'(k), !k[0], k[0], 2'b00};
      e1 = (4500 / (fan_tach_pkg::TACH_BASE_CYCLES_INT << k)) * (k[0] ? 2 : 1);
      e2 = (4500 / (fan_tach_pkg::TACH_BASE_CYCLES_INT << (3 - k))) * (k[0] ? 1 : 2);
      bus(1'b1, 8'h00, c, q);
      repeat (13500) @(posedge clk);
      bus(1'b0, 8'h00, 8'h00, q);
      chk("ctrl", c, q);
      bus(1'b0, 8'h04, 8'h00, q);
      chk("first count", 8'(e1), q);
      bus(1'b1, 8'h04, 8'hA5, q);
      bus(1'b0, 8'h04, 8'h00, q);
      chk("first count", 8'(e1), q);
      bus(1'b0, 8'h08, 8'h00, q);
      chk("second count", 8'(e2), q);
    end
  endtask
  // Lane 0 gates control writes; then a reset in mid-run clears counts and control.
  task automatic t_lane_and_reset();
    logic [7:0] q;
    period <= 16'h0000;
    bus(1'b1, 8'h00, 8'h9C, q);
    lanes = 4'hE;
    bus(1'b1, 8'h00, 8'h63, q);
    lanes = 4'hF;
    bus(1'b0, 8'h00, 8'h00, q);
    chk("ctrl", 8'h9C, q);
    bus(1'b0, 8'h08, 8'h00, q);
    chk("second count", 8'h04, q);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, 8'h00, 8'h00, q);
    chk("ctrl", fan_tach_pkg::CTRL_RESET, q);
    bus(1'b0, 8'h04, 8'h00, q);
    chk("first count", 8'h00, q);
    bus(1'b0, 8'h08, 8'h00, q);
    chk("second count", 8'h00, q);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Watchdog well beyond the roughly 55000 cycles the tests need.
  initial begin
    repeat (80000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
  initial begin
    nrst = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h00000000;
    sel = 4'h0;
    lanes = 4'hF;
    period = 16'h0000;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset_and_readonly();
    t_divisors();
    t_lane_and_reset();
    wrap_up();
  end
endmodule
